// File: logic/ccs_defines.vh
// Constants for the call, compare and skip execution unit.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
//
// Overview of operation
// - Indirect call loads PC from the 16-bit pointer, keeps flags, takes 3 cycles.
// - Direct call loads PC from the absolute target, keeps flags, takes 4 cycles.
// - Subroutine exit restores PC from the stack, keeps flags, takes 4 cycles.
// - Interrupt exit restores PC from the stack, sets I, takes 4 cycles.
// - Compare-skip-equal skips next instruction when both registers match; flags kept.
// - Compare computes destination minus source, sets Z N V C H, one cycle.
// - Compare with borrow also subtracts carry, sets Z N V C H, one cycle.
// - Compare immediate subtracts opcode constant, discards result, sets flags, one cycle.
// - Skip when the selected source register bit is zero.
// - Skip when the selected source register bit is one; flags kept.
// - Skip when the selected I/O bit is zero; flags kept.
// - Skip when the selected I/O bit is one; flags kept.
// - Branch when selected status bit is one: PC becomes PC plus offset plus one.
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// Register byte offsets
`define CCS_OFF_INSTR   8'h00
`define CCS_OFF_OPND    8'h04
`define CCS_OFF_ZPTR    8'h08
`define CCS_OFF_PC      8'h0c
`define CCS_OFF_STATUS  8'h10
`define CCS_OFF_SP      8'h14
`define CCS_OFF_STAT    8'h18

// Instruction word fields
`define CCS_F_OP        3:0
`define CCS_F_BIT       6:4
`define CCS_F_IMM       15:8
`define CCS_F_OFS       14:8
`define CCS_F_TGT       31:16

// Operand word fields
`define CCS_F_DST       7:0
`define CCS_F_SRC       15:8
`define CCS_F_IO        23:16
`define CCS_B_TWO       24

// Status register bit positions
`define CCS_SR_C        0
`define CCS_SR_Z        1
`define CCS_SR_N        2
`define CCS_SR_V        3
`define CCS_SR_H        5
`define CCS_SR_I        7

// Operation codes
`define CCS_OP_IND_CALL 4'h0
`define CCS_OP_CALL     4'h1
`define CCS_OP_SUB_EXIT 4'h2
`define CCS_OP_INT_EXIT 4'h3
`define CCS_OP_CMP_SKIP 4'h4
`define CCS_OP_CMP      4'h5
`define CCS_OP_CMP_BRW  4'h6
`define CCS_OP_CMP_IMM  4'h7
`define CCS_OP_SKIP_RC  4'h8
`define CCS_OP_SKIP_RS  4'h9
`define CCS_OP_SKIP_IC  4'ha
`define CCS_OP_SKIP_IS  4'hb
`define CCS_OP_BR_SET   4'hc

// Cycle counts
`define CCS_CYC_IND     3'h3
`define CCS_CYC_CALL    3'h4
`define CCS_CYC_EXIT    3'h4
`define CCS_CYC_ONE     3'h1
`define CCS_CYC_BRANCH  3'h2

// Reset values
`define CCS_RST_PC      16'h0000
`define CCS_RST_STATUS  8'h00

// AXI responses
`define CCS_RESP_OKAY   2'h0
`define CCS_RESP_SLVERR 2'h2

`endif

// File: logic/ccs_sub.v
// Eight-bit compare: subtract with optional borrow, flags only.
// Assumes the caller discards the difference and merges flags itself.
`timescale 1ns/1ps
module ccs_sub
(
  // Operands
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       cin,
  // Zero chaining for multi-byte compares
  input  wire       chain,
  input  wire       zin,
  // Flags
  output wire       c,
  output wire       z,
  output wire       n,
  output wire       v,
  output wire       h
);

  wire [8:0] diff;
  wire [7:0] r;

  assign diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  assign r    = diff[7:0];
  assign c    = diff[8];
  assign n    = r[7];
  assign v    = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  assign h    = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  // Chained compare only clears zero, so wide compares stay correct
  assign z    = (r == 8'h00) & (~chain | zin);

endmodule // ccs_sub

// File: logic/ccs_unit.v
// Call, return, compare, skip and branch execution unit with AXI4-Lite registers.
// Assumes software loads operands before writing the instruction word.
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_unit
#(
  parameter STACK_DEPTH = 16,
  parameter SP_W        = 4
)
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write address channel
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // Write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // Write response channel
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // Read address channel
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // Read data channel
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  // Bus holding registers
  reg              aw_got_reg;
  reg  [7:0]       aw_addr_reg;
  reg              w_got_reg;
  reg  [31:0]      w_data_reg;
  reg  [3:0]       w_strb_reg;

  // Architectural state
  reg  [31:0]      instr_reg;
  reg  [31:0]      opnd_reg;
  reg  [15:0]      z_reg;
  reg  [15:0]      pc_reg;
  reg  [7:0]       status_reg;
  reg  [SP_W-1:0]  sp_reg;
  reg  [15:0]      stk [0:STACK_DEPTH-1];

  // Execution state
  reg              busy_reg;
  reg  [2:0]       cnt_reg;
  reg  [2:0]       cyc_last_reg;
  reg              err_reg;
  reg  [15:0]      pc_pend_reg;
  reg  [7:0]       status_pend_reg;

  wire             wr_go;
  wire [31:0]      ins_new;
  wire [3:0]       op;
  wire [2:0]       bsel;
  wire [7:0]       rd_val;
  wire [7:0]       src_val;
  wire [31:0]      z_merged;
  wire [7:0]       io_val;
  wire [15:0]      skip_len;
  wire [15:0]      stk_top;
  wire             f_c;
  wire             f_z;
  wire             f_n;
  wire             f_v;
  wire             f_h;
  wire             start;

  reg  [15:0]      nxt_pc;
  reg  [7:0]       nxt_status;
  reg  [2:0]       cyc;
  reg  [15:0]      ret_addr;
  reg              push;
  reg              pop;
  reg              bad;
  reg  [7:0]       cmp_b;
  reg              cmp_cin;
  reg              cmp_chain;
  reg              skip;
  reg  [31:0]      rd_mux;
  reg              rd_ok;

  assign wr_go    = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  assign ins_new  = merge(instr_reg, w_data_reg, w_strb_reg);
  assign op       = ins_new[`CCS_F_OP];
  assign bsel     = ins_new[`CCS_F_BIT];
  assign rd_val   = opnd_reg[`CCS_F_DST];
  assign src_val  = opnd_reg[`CCS_F_SRC];
  assign z_merged = merge({16'h0000, z_reg}, w_data_reg, w_strb_reg);
  assign io_val   = opnd_reg[`CCS_F_IO];
  assign skip_len = opnd_reg[`CCS_B_TWO] ? 16'h0003 : 16'h0002;
  assign stk_top  = stk[sp_reg - {{(SP_W-1){1'b0}}, 1'b1}];
  assign start    = wr_go & (aw_addr_reg == `CCS_OFF_INSTR) & ~busy_reg;

  ccs_sub u_sub
  (
    .a     (rd_val),
    .b     (cmp_b),
    .cin   (cmp_cin),
    .chain (cmp_chain),
    .zin   (status_reg[`CCS_SR_Z]),
    .c     (f_c),
    .z     (f_z),
    .n     (f_n),
    .v     (f_v),
    .h     (f_h)
  );

  // Decode of the instruction being written
  always @*
  begin
    nxt_pc    = pc_reg + 16'h0001;
    nxt_status = status_reg;
    cyc       = `CCS_CYC_ONE;
    ret_addr  = pc_reg + 16'h0001;
    push      = 1'b0;
    pop       = 1'b0;
    bad       = 1'b0;
    cmp_b     = src_val;
    cmp_cin   = 1'b0;
    cmp_chain = 1'b0;
    skip      = 1'b0;
    case (op)
      `CCS_OP_IND_CALL:
      begin
        nxt_pc = z_reg;
        push   = 1'b1;
        cyc    = `CCS_CYC_IND;
      end
      `CCS_OP_CALL:
      begin
        nxt_pc   = ins_new[`CCS_F_TGT];
        ret_addr = pc_reg + 16'h0002;
        push     = 1'b1;
        cyc      = `CCS_CYC_CALL;
      end
      `CCS_OP_SUB_EXIT:
      begin
        nxt_pc = stk_top;
        pop    = 1'b1;
        cyc    = `CCS_CYC_EXIT;
      end
      `CCS_OP_INT_EXIT:
      begin
        nxt_pc                = stk_top;
        nxt_status[`CCS_SR_I] = 1'b1;
        pop                   = 1'b1;
        cyc                   = `CCS_CYC_EXIT;
      end
      `CCS_OP_CMP_SKIP:
        skip = (rd_val == src_val);
      `CCS_OP_CMP, `CCS_OP_CMP_BRW, `CCS_OP_CMP_IMM:
      begin
        if (op == `CCS_OP_CMP_IMM)
          cmp_b = ins_new[`CCS_F_IMM];
        if (op == `CCS_OP_CMP_BRW)
        begin
          cmp_cin   = status_reg[`CCS_SR_C];
          cmp_chain = 1'b1;
        end
        nxt_status[`CCS_SR_C] = f_c;
        nxt_status[`CCS_SR_Z] = f_z;
        nxt_status[`CCS_SR_N] = f_n;
        nxt_status[`CCS_SR_V] = f_v;
        nxt_status[`CCS_SR_H] = f_h;
      end
      `CCS_OP_SKIP_RC:
        skip = ~src_val[bsel];
      `CCS_OP_SKIP_RS:
        skip = src_val[bsel];
      `CCS_OP_SKIP_IC:
        skip = ~io_val[bsel];
      `CCS_OP_SKIP_IS:
        skip = io_val[bsel];
      `CCS_OP_BR_SET:
        if (status_reg[bsel])
        begin
          nxt_pc = pc_reg + {{9{ins_new[14]}}, ins_new[`CCS_F_OFS]} + 16'h0001;
          cyc    = `CCS_CYC_BRANCH;
        end
      default:
        bad = 1'b1;
    endcase
    if (skip)
    begin
      nxt_pc = pc_reg + skip_len;
      cyc    = skip_len[2:0];
    end
  end

  // Return stack storage, no reset needed
  always @(posedge aclk)
  begin
    if (start & push & ~bad)
      stk[sp_reg] <= ret_addr;
  end

  // Write channels; address and data accepted in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_got_reg     <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_got_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_got_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `CCS_OFF_OPND, `CCS_OFF_ZPTR, `CCS_OFF_STAT:
            s_axi_bresp <= `CCS_RESP_OKAY;
          // State that execution owns is locked while busy
          `CCS_OFF_INSTR, `CCS_OFF_PC, `CCS_OFF_STATUS, `CCS_OFF_SP:
            s_axi_bresp <= busy_reg ? `CCS_RESP_SLVERR : `CCS_RESP_OKAY;
          default:
            s_axi_bresp <= `CCS_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes and execution sequencing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr_reg     <= 32'h0000_0000;
      opnd_reg      <= 32'h0000_0000;
      z_reg         <= 16'h0000;
      pc_reg        <= `CCS_RST_PC;
      status_reg    <= `CCS_RST_STATUS;
      sp_reg        <= {SP_W{1'b0}};
      busy_reg      <= 1'b0;
      cnt_reg       <= 3'h0;
      cyc_last_reg  <= 3'h0;
      err_reg       <= 1'b0;
      pc_pend_reg   <= 16'h0000;
      status_pend_reg <= 8'h00;
    end
    else
    begin
      if (busy_reg)
      begin
        cnt_reg <= cnt_reg - 3'h1;
        if (cnt_reg == 3'h1)
        begin
          busy_reg <= 1'b0;
          pc_reg     <= pc_pend_reg;
          status_reg <= status_pend_reg;
        end
      end
      if (wr_go)
      begin
        case (aw_addr_reg)
          `CCS_OFF_OPND:
            opnd_reg <= merge(opnd_reg, w_data_reg, w_strb_reg) & 32'h01ff_ffff;
          `CCS_OFF_ZPTR:
            z_reg <= z_merged[15:0];
          `CCS_OFF_PC:
            if (!busy_reg)
              pc_reg <= w_strb_reg[1:0] == 2'h3 ? w_data_reg[15:0] : pc_reg;
          `CCS_OFF_STATUS:
            if (!busy_reg && w_strb_reg[0])
              status_reg <= w_data_reg[7:0];
          `CCS_OFF_SP:
            if (!busy_reg && w_strb_reg[0])
              sp_reg <= w_data_reg[SP_W-1:0];
          default:
            ;
        endcase
      end
      if (start)
      begin
        instr_reg    <= ins_new;
        err_reg      <= bad;
        cyc_last_reg <= bad ? 3'h0 : cyc;
        if (!bad)
        begin
          if (push)
            sp_reg <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
          if (pop)
            sp_reg <= sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
          if (cyc == `CCS_CYC_ONE)
          begin
            pc_reg     <= nxt_pc;
            status_reg <= nxt_status;
          end
          else
          begin
            busy_reg      <= 1'b1;
            cnt_reg       <= cyc - 3'h1;
            pc_pend_reg     <= nxt_pc;
            status_pend_reg <= nxt_status;
          end
        end
      end
    end
  end

  // Read mux
  always @*
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `CCS_OFF_INSTR: rd_mux = instr_reg;
      `CCS_OFF_OPND:  rd_mux = opnd_reg;
      `CCS_OFF_ZPTR:  rd_mux = {16'h0000, z_reg};
      `CCS_OFF_PC:    rd_mux = {16'h0000, pc_reg};
      `CCS_OFF_STATUS: rd_mux = {24'h000000, status_reg};
      `CCS_OFF_SP:    rd_mux[SP_W-1:0] = sp_reg;
      `CCS_OFF_STAT:  rd_mux = {25'h0, cyc_last_reg, 2'h0, err_reg, busy_reg};
      default:        rd_ok = 1'b0;
    endcase
  end

  // Read channels
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ccs_unit

// File: tb/ccs_unit_properties.sv
// Checker on the register bus ports of the call, compare and skip unit.
// Assumes the bind below attaches it to every ccs_unit instance.
`timescale 1ns/1ps
module ccs_unit_props
#(
  parameter STACK_DEPTH = 16,
  parameter SP_W        = 4
)
(
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Write channels
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_quiet_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during answer");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  bvalid_drops_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rvalid_drops_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule // ccs_unit_props

bind ccs_unit ccs_unit_props #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) i_ccs_unit_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// File: tb/ccs_unit_tb.sv
// Testbench for the call, compare and skip unit, driven over its register bus.
// Assumes the unit answers every bus request within a few cycles.
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_unit_tb;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr;
  reg         awvalid;
  reg  [31:0] wdata;
  reg         wvalid;
  reg  [7:0]  araddr;
  reg         arvalid;
  wire        awready;
  wire        wready;
  wire [1:0]  bresp;
  wire        bvalid;
  wire        arready;
  wire [31:0] rdata;
  wire [1:0]  rresp;
  wire        rvalid;
  integer     bad_count;
  integer     n_checks;
  reg  [31:0] d;
  reg  [1:0]  r;

  ccs_unit i_ccs_unit (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1)
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // Both channels offered together, each released once taken
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    reg a_ok;
    reg d_ok;
  begin
    a_ok = 1'b0;
    d_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_ok && d_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready)
        a_ok = 1'b1;
      if (wvalid && wready)
        d_ok = 1'b1;
      if (a_ok)
        awvalid <= 1'b0;
      if (d_ok)
        wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
  end
  endtask

  task rd(input [7:0] a, output [31:0] v, output [1:0] rsp);
  begin
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rsp = rresp;
  end
  endtask

  // Load operands, start one instruction, wait until idle, check results
  task run(input [31:0] ins, input [31:0] op, input [15:0] z, input [15:0] pc,
           input [7:0] sr, input [15:0] epc, input [7:0] esr, input [2:0] cyc);
  begin
    wr(`CCS_OFF_OPND, op, `CCS_RESP_OKAY);
    wr(`CCS_OFF_ZPTR, {16'h0, z}, `CCS_RESP_OKAY);
    wr(`CCS_OFF_PC, {16'h0, pc}, `CCS_RESP_OKAY);
    wr(`CCS_OFF_STATUS, {24'h0, sr}, `CCS_RESP_OKAY);
    wr(`CCS_OFF_INSTR, ins, `CCS_RESP_OKAY);
    do rd(`CCS_OFF_STAT, d, r); while (d[0] === 1'b1);
    chk({29'h0, d[6:4]}, {29'h0, cyc});
    rd(`CCS_OFF_PC, d, r);
    chk(d, {16'h0, epc});
    rd(`CCS_OFF_STATUS, d, r);
    chk(d, {24'h0, esr});
  end
  endtask

  task complete_run;
  begin
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  initial
  begin
    #400000;
    bad_count = bad_count + 1;
    complete_run;
  end

  initial
  begin
    bad_count = 0;
    n_checks = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CCS_OFF_PC, d, r);
    chk(d, 32'h0);
    rd(`CCS_OFF_STATUS, d, r);
    chk(d, 32'h0);
    rd(8'h1c, d, r);
    chk({d[29:0], r}, {30'h0, `CCS_RESP_SLVERR});
    wr(8'h20, 32'h1, `CCS_RESP_SLVERR);
    wr(`CCS_OFF_STAT, 32'h7, `CCS_RESP_OKAY);
    // Calls and the exits that come back from them
    run(32'h0, 32'h0, 16'h1234, 16'h0010, 8'h2b, 16'h1234, 8'h2b, 3'h3);
    rd(`CCS_OFF_SP, d, r);
    chk(d, 32'h1);
    run(32'h2, 32'h0, 16'h0, 16'h0777, 8'h15, 16'h0011, 8'h15, 3'h4);
    run(32'hbeef_0001, 32'h0, 16'h0, 16'h0100, 8'h00, 16'hbeef, 8'h00, 3'h4);
    run(32'h3, 32'h0, 16'h0, 16'h0555, 8'h00, 16'h0102, 8'h80, 3'h4);
    // Compares set flags only, pc steps by one
    run(32'h5, 32'h2010, 16'h0, 16'h0020, 8'h80, 16'h0021, 8'h85, 3'h1);
    run(32'h5, 32'h5555, 16'h0, 16'h0020, 8'h00, 16'h0021, 8'h02, 3'h1);
    run(32'h6, 32'h0000, 16'h0, 16'h0020, 8'h03, 16'h0021, 8'h25, 3'h1);
    run(32'h6, 32'h0505, 16'h0, 16'h0020, 8'h00, 16'h0021, 8'h00, 3'h1);
    run(32'h8007, 32'h007f, 16'h0, 16'h0020, 8'h00, 16'h0021, 8'h0d, 3'h1);
    // Skips over one-word and two-word followers
    run(32'h4, 32'h9a9a, 16'h0, 16'h0030, 8'h2b, 16'h0032, 8'h2b, 3'h2);
    run(32'h4, 32'h0100_9a9a, 16'h0, 16'h0030, 8'h2b, 16'h0033, 8'h2b, 3'h3);
    run(32'h4, 32'h9a9b, 16'h0, 16'h0030, 8'h2b, 16'h0031, 8'h2b, 3'h1);
    run(32'h08, 32'hfe00, 16'h0, 16'h0030, 8'h21, 16'h0032, 8'h21, 3'h2);
    run(32'h78, 32'hfe00, 16'h0, 16'h0030, 8'h21, 16'h0031, 8'h21, 3'h1);
    run(32'h79, 32'h0100_8000, 16'h0, 16'h0030, 8'h21, 16'h0033, 8'h21, 3'h3);
    run(32'h4a, 32'h0010_0000, 16'h0, 16'h0030, 8'h21, 16'h0031, 8'h21, 3'h1);
    run(32'h4a, 32'h00ef_0000, 16'h0, 16'h0030, 8'h21, 16'h0032, 8'h21, 3'h2);
    run(32'h4b, 32'h0010_0000, 16'h0, 16'h0030, 8'h21, 16'h0032, 8'h21, 3'h2);
    // Branch backwards when taken, fall through otherwise
    run(32'h7e1c, 32'h0, 16'h0, 16'h0040, 8'h02, 16'h003f, 8'h02, 3'h2);
    run(32'h7e1c, 32'h0, 16'h0, 16'h0040, 8'h00, 16'h0041, 8'h00, 3'h1);
    // Unused operation code only raises the illegal flag
    wr(`CCS_OFF_INSTR, 32'hd, `CCS_RESP_OKAY);
    rd(`CCS_OFF_STAT, d, r);
    chk(d, 32'h2);
    rd(`CCS_OFF_PC, d, r);
    chk(d, 32'h41);
    complete_run;
  end
endmodule // ccs_unit_tb
